// ---- verilog/poseq_top.sv ----
`default_nettype none

// Print output sequencer: reads display memory, inserts line codes, shifts out
module poseq_top import poseq_pkg::*; #(
    parameter int BAUD_W = 16
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic printer_busy_i,
    input wire logic ext_shift_clk_i,
    input wire logic [6:0] mem_data_i,
    output logic mem_read_restore_o,
    output logic [6:0] cursor_col_o,
    output logic [4:0] cursor_row_o,
    output logic cursor_advance_pulse_o,
    output logic cursor_column_increment_o,
    output logic cursor_row_increment_o,
    output logic clear_cursor_column_o,
    output logic load_pulse_o,
    output logic [6:0] par_data_o,
    output logic ser_data_o,
    output logic print_active_o,
    output logic receive_mode_o
);

    // Synchronised pins
    logic [1:0] pins_s;
    logic busy_s; // Printer occupied
    logic ext_s; // Peripheral shift clock
    logic ext_prev_reg; // Previous peripheral clock level

    // Control and mode state
    poseq_state_t state_reg;
    logic print_reg; // Print mode active
    logic receive_reg; // Receive mode
    logic record_reg; // Cassette recording
    logic ext_sel_reg; // Peripheral clock selected
    logic [BAUD_W-1:0] baud_div_reg; // Internal bit period in clocks
    logic [BAUD_W-1:0] baud_cnt_reg;

    // Cursor
    logic [6:0] col_reg;
    logic [4:0] row_reg;
    logic column_at_origin;

    // Auto-send sequencer
    logic auto_send_reg; // Inserting a code this window
    logic lf_pending_reg; // Return sent, newline still owed
    logic lf_sent_reg; // Newline loaded this window
    logic follow_up_reg; // Blocks insertion for one window
    logic [1:0] eot_cnt_reg;
    logic [6:0] mem_char_reg; // Character read from store

    // Shifter
    logic internal_shift_clock_gate_reg; // High holds the shifter stopped
    logic [11:0] shreg_reg;
    logic [3:0] bit_cnt_reg;
    logic shift_tick;
    logic int_tick;

    // Bus
    logic bus_req;
    logic bus_take;
    logic start_pulse;

    // Decision of the current window
    logic auto_send_next;
    logic return_code_from_store;
    logic end_marker_from_store;
    logic [6:0] send_char;
    logic col_inc, row_inc, col_clr, eot_step, eot_clear;
    logic lf_pend_set, lf_pend_clr, lf_sent_set, col_wrap;

    poseq_sync #(.W(2)) u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i({ext_shift_clk_i, printer_busy_i}),
        .q_o(pins_s)
    );
    assign busy_s = pins_s[0];
    assign ext_s = pins_s[1];

    assign column_at_origin = (col_reg == COL_ORIGIN);
    assign return_code_from_store = (mem_char_reg == CODE_CR);
    assign end_marker_from_store = (mem_char_reg == CODE_EOT);
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_take = bus_req & ~avs_waitrequest_o;
    assign start_pulse = bus_take & avs_write_i & (avs_address_i == ADDR_CTRL) & avs_writedata_i[CTRL_START];

    // Window decision; stored characters are sent whatever their intensity, except markers (sent as return) and the cell after a lone marker
    always_comb begin
        auto_send_next = ~record_reg & ~follow_up_reg & (eot_cnt_reg == EOT_NONE)
                         & (lf_pending_reg | column_at_origin);
        send_char = mem_char_reg;
        col_inc = 1'b0;
        row_inc = 1'b0;
        col_clr = 1'b0;
        eot_step = 1'b0;
        eot_clear = 1'b0;
        lf_pend_set = 1'b0;
        lf_pend_clr = 1'b0;
        lf_sent_set = 1'b0;
        if (auto_send_next) begin
            // Memory character blocked, no cursor move
            if (lf_pending_reg) begin
                send_char = CODE_LF;
                lf_pend_clr = 1'b1;
                lf_sent_set = 1'b1;
            end else begin
                send_char = CODE_CR;
                lf_pend_set = 1'b1;
            end
        end else if (end_marker_from_store) begin
            // Return first, then look at the next cell
            send_char = CODE_CR;
            eot_step = 1'b1;
            col_inc = 1'b1;
        end else if (eot_cnt_reg == EOT_ONE) begin
            // Cell after a lone marker: newline, next line
            send_char = CODE_LF;
            row_inc = 1'b1;
            col_clr = 1'b1;
            eot_clear = 1'b1;
            lf_sent_set = 1'b1;
        end else if (return_code_from_store) begin
            // Sent unchanged, row steps, newline owed unless recording
            row_inc = 1'b1;
            col_clr = 1'b1;
            lf_pend_set = ~record_reg;
        end else begin
            col_inc = 1'b1;
        end
    end
    assign col_wrap = col_inc & (col_reg == COL_LAST);

    // Bus slave: one wait cycle, then answer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (avs_waitrequest_o) begin
            avs_waitrequest_o <= ~bus_req;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Read data captured while waitrequest is still high
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= '0;
            if (avs_address_i == ADDR_CTRL) begin
                avs_readdata_o[CTRL_RECORD] <= record_reg;
                avs_readdata_o[CTRL_EXTCLK] <= ext_sel_reg;
            end else if (avs_address_i == ADDR_BAUD) begin
                avs_readdata_o[BAUD_W-1:0] <= baud_div_reg;
            end else if (avs_address_i == ADDR_STAT) begin
                avs_readdata_o[STAT_PRINT] <= print_reg;
                avs_readdata_o[STAT_RECV] <= receive_reg;
                avs_readdata_o[STAT_BUSY] <= busy_s;
                avs_readdata_o[STAT_SHIFT] <= ~internal_shift_clock_gate_reg;
                avs_readdata_o[STAT_EOT_LO +: 2] <= eot_cnt_reg;
                avs_readdata_o[STAT_COL_LO +: 7] <= col_reg;
                avs_readdata_o[STAT_ROW_LO +: 5] <= row_reg;
            end else if (avs_address_i == ADDR_CURS) begin
                avs_readdata_o[CURS_COL_LO +: 7] <= col_reg;
                avs_readdata_o[CURS_ROW_LO +: 5] <= row_reg;
            end
        end
    end

    // Software configuration
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            record_reg <= 1'b0;
            ext_sel_reg <= 1'b0;
            baud_div_reg <= BAUD_W'(BAUD_DIV_RST);
        end else if (bus_take && avs_write_i) begin
            if (avs_address_i == ADDR_CTRL) begin
                record_reg <= avs_writedata_i[CTRL_RECORD];
                ext_sel_reg <= avs_writedata_i[CTRL_EXTCLK];
            end else if (avs_address_i == ADDR_BAUD) begin
                baud_div_reg <= avs_writedata_i[BAUD_W-1:0];
            end
        end
    end

    // Mode flags; double marker hands over to receive
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            print_reg <= 1'b0;
            receive_reg <= 1'b1;
        end else if (start_pulse && !print_reg) begin
            print_reg <= 1'b1;
            receive_reg <= 1'b0;
        end else if (state_reg == ST_SHIFT && internal_shift_clock_gate_reg && eot_cnt_reg == EOT_LIMIT) begin
            print_reg <= 1'b0;
            receive_reg <= 1'b1;
        end
    end

    // Main sequence; busy holds the request state
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_pulse) begin
                        state_reg <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (!busy_s) begin
                        state_reg <= ST_READ;
                    end
                end
                ST_READ: state_reg <= ST_FETCH;
                ST_FETCH: state_reg <= ST_LEAD;
                ST_LEAD: state_reg <= ST_TRAIL;
                ST_TRAIL: state_reg <= ST_SHIFT;
                ST_SHIFT: begin
                    // Gate set again means the frame is out
                    if (internal_shift_clock_gate_reg) begin
                        state_reg <= (eot_cnt_reg == EOT_LIMIT) ? ST_IDLE : ST_REQ;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Read-restore strobe, only when printer is free
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_read_restore_o <= 1'b0;
        end else begin
            mem_read_restore_o <= (state_reg == ST_REQ) && !busy_s;
        end
    end

    // Store data valid the cycle after the strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_char_reg <= '0;
        end else if (state_reg == ST_FETCH) begin
            mem_char_reg <= mem_data_i;
        end
    end

    // Cursor position, changed at the window's leading edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            col_reg <= COL_ORIGIN;
            row_reg <= ROW_FIRST;
        end else if (bus_take && avs_write_i && avs_address_i == ADDR_CURS && !print_reg) begin
            col_reg <= avs_writedata_i[CURS_COL_LO +: 7];
            row_reg <= avs_writedata_i[CURS_ROW_LO +: 5];
        end else if (state_reg == ST_LEAD) begin
            if (col_clr || col_wrap) begin
                col_reg <= COL_ORIGIN;
            end else if (col_inc) begin
                col_reg <= col_reg + 7'h01;
            end
            // Row wraps; roll-up of the screen is handled elsewhere
            if (row_inc || col_wrap) begin
                row_reg <= (row_reg == ROW_LAST) ? ROW_FIRST : row_reg + 5'h01;
            end
        end
    end

    // Cursor pulses, none while inserting
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cursor_advance_pulse_o <= 1'b0;
            cursor_column_increment_o <= 1'b0;
            cursor_row_increment_o <= 1'b0;
            clear_cursor_column_o <= 1'b0;
        end else begin
            cursor_advance_pulse_o <= (state_reg == ST_LEAD) && (col_inc || row_inc);
            cursor_column_increment_o <= (state_reg == ST_LEAD) && col_inc && !col_wrap;
            cursor_row_increment_o <= (state_reg == ST_LEAD) && (row_inc || col_wrap);
            clear_cursor_column_o <= (state_reg == ST_LEAD) && (col_clr || col_wrap);
        end
    end

    // Auto-send state counter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            auto_send_reg <= 1'b0;
            lf_pending_reg <= 1'b0;
            lf_sent_reg <= 1'b0;
            follow_up_reg <= 1'b0;
        end else if (start_pulse && !print_reg) begin
            auto_send_reg <= 1'b0;
            lf_pending_reg <= 1'b0;
            lf_sent_reg <= 1'b0;
            follow_up_reg <= 1'b0;
        end else if (state_reg == ST_LEAD) begin
            auto_send_reg <= auto_send_next;
            lf_sent_reg <= lf_sent_set;
            if (lf_pend_set) begin
                lf_pending_reg <= 1'b1;
            end else if (lf_pend_clr) begin
                lf_pending_reg <= 1'b0;
            end
        end else if (state_reg == ST_TRAIL) begin
            if (lf_sent_reg) begin
                follow_up_reg <= 1'b1;
            end else if (follow_up_reg) begin
                follow_up_reg <= 1'b0;
            end
            lf_sent_reg <= 1'b0;
        end
    end

    // End marker counter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            eot_cnt_reg <= EOT_NONE;
        end else if (start_pulse && !print_reg) begin
            eot_cnt_reg <= EOT_NONE;
        end else if (state_reg == ST_LEAD) begin
            if (eot_step) begin
                eot_cnt_reg <= eot_cnt_reg + EOT_ONE;
            end else if (eot_clear) begin
                eot_cnt_reg <= EOT_NONE;
            end
        end else if (state_reg == ST_SHIFT && internal_shift_clock_gate_reg && eot_cnt_reg == EOT_LIMIT) begin
            eot_cnt_reg <= EOT_NONE;
        end
    end

    // Load pulse and parallel output, one per window
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            load_pulse_o <= 1'b0;
            par_data_o <= '0;
        end else begin
            load_pulse_o <= (state_reg == ST_LEAD);
            if (state_reg == ST_LEAD) begin
                par_data_o <= send_char;
            end
        end
    end

    // Internal bit clock runs only while the gate is open
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            baud_cnt_reg <= '0;
        end else if (internal_shift_clock_gate_reg || ext_sel_reg || int_tick) begin
            baud_cnt_reg <= '0;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + BAUD_W'(1);
        end
    end
    // A divisor of zero behaves as one
    assign int_tick = ~internal_shift_clock_gate_reg & ~ext_sel_reg
                      & (baud_cnt_reg + BAUD_W'(1) >= baud_div_reg);

    // Peripheral clock edge, from the synchronised level only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_s;
        end
    end
    // External select masks the internal source
    assign shift_tick = ext_sel_reg ? (~internal_shift_clock_gate_reg & ext_s & ~ext_prev_reg) : int_tick;

    // Shift register, gate and bit counter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            internal_shift_clock_gate_reg <= 1'b1;
            shreg_reg <= '1;
            bit_cnt_reg <= '0;
            ser_data_o <= 1'b1;
        end else if (state_reg == ST_LEAD) begin
            internal_shift_clock_gate_reg <= 1'b0;
            shreg_reg <= {FRAME_STOPS, 1'b0, send_char, 1'b0};
            bit_cnt_reg <= '0;
        end else if (shift_tick) begin
            ser_data_o <= shreg_reg[0];
            shreg_reg <= {1'b1, shreg_reg[11:1]};
            if (bit_cnt_reg + 4'h1 == BIT_END) begin
                internal_shift_clock_gate_reg <= 1'b1;
                bit_cnt_reg <= '0;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // Status pins
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            print_active_o <= 1'b0;
            receive_mode_o <= 1'b1;
            cursor_col_o <= COL_ORIGIN;
            cursor_row_o <= ROW_FIRST;
        end else begin
            print_active_o <= print_reg;
            receive_mode_o <= receive_reg;
            cursor_col_o <= col_reg;
            cursor_row_o <= row_reg;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_window;
        state_reg == ST_LEAD ##1 state_reg == ST_TRAIL;
    endsequence
    sequence s_auto_return_request;
        state_reg == ST_LEAD && auto_send_next && !lf_pending_reg;
    endsequence

    a_busy_holds: assert property (state_reg == ST_REQ && busy_s |=> !mem_read_restore_o && state_reg == ST_REQ)
        else $error("read strobe issued while printer busy");
    a_load_window: assert property (s_window |-> load_pulse_o ##1 !load_pulse_o)
        else $error("load pulse not one per window");
    a_load_gate: assert property ($rose(load_pulse_o) |-> !internal_shift_clock_gate_reg && bit_cnt_reg == 4'h0)
        else $error("load did not open shift gate");
    a_stop_twelve: assert property (shift_tick && bit_cnt_reg == (BIT_END - 4'h1)
                                    |=> internal_shift_clock_gate_reg && bit_cnt_reg == 4'h0)
        else $error("shifter not stopped at twelve");
    a_auto_return: assert property (s_auto_return_request |=> par_data_o == CODE_CR && !cursor_advance_pulse_o ##5 1)
        else $error("auto insert did not send return");
    a_auto_still: assert property (auto_send_reg && $rose(load_pulse_o) |-> !cursor_advance_pulse_o)
        else $error("cursor moved during insertion");
    a_newline_next: assert property (state_reg == ST_LEAD && auto_send_next && lf_pending_reg
                                     |=> par_data_o == CODE_LF)
        else $error("newline not sent after inserted return");
    a_follow_set: assert property (state_reg == ST_TRAIL && lf_sent_reg |=> follow_up_reg)
        else $error("follow-up not set after newline");
    a_col_wrap: assert property (state_reg == ST_LEAD && col_inc && col_reg == COL_LAST
                                 |=> col_reg == COL_ORIGIN && clear_cursor_column_o)
        else $error("column did not wrap after 73");
    a_store_return: assert property (state_reg == ST_LEAD && !auto_send_next && return_code_from_store
                                     && eot_cnt_reg == EOT_NONE |=> cursor_row_increment_o && clear_cursor_column_o)
        else $error("stored return did not step row");
    a_double_end: assert property (state_reg == ST_SHIFT && internal_shift_clock_gate_reg && eot_cnt_reg == EOT_LIMIT
                                   |=> !print_reg && receive_reg && state_reg == ST_IDLE)
        else $error("double end marker did not stop print");
    // Bit count may only move on a peripheral edge while that clock is selected
    a_ext_masks: assert property (ext_sel_reg && state_reg == ST_SHIFT && !(ext_s && !ext_prev_reg)
                                  |=> $stable(bit_cnt_reg))
        else $error("shifter moved without a peripheral clock edge");

endmodule // poseq_top

`default_nettype wire

// ---- verilog/poseq_pkg.sv ----
// Functional notes
// - Printer busy withholds read strobe and window
// - Print mode sends foreground and background characters
// - One load pulse per cursor step window
// - Load captures character, parallel and serial out
// - Load pulse clears shift clock gate
// - Shift clock internal baud or peripheral clock
// - Count twelve stops shift, clears count, requests
// - Insert return, newline after each column wrap; nothing inserted while recording
// - Column 73 advance wraps to next line
// - Auto insert sets at origin, sends return
// - Auto insert suppresses cursor advance
// - Second auto insert cycle sends newline code
// - Follow-up set after newline, blocks auto insert
// - Follow-up clears after column-zero character window
// - Stored return sent, then newline inserted; no newline while recording
// - Stored return steps row and clears column
// - End marker sends return; newline follows only a lone marker
// - Two adjacent end markers enter receive mode
// - Blank after end marker resumes at column zero
// - End marker count two unlocks, clears print
`default_nettype none

package poseq_pkg;

    // Clock and default line rate
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BAUD_DEFAULT = 300;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_DEFAULT);

    // Character codes
    localparam logic [6:0] CODE_CR = 7'h0D;
    localparam logic [6:0] CODE_LF = 7'h0A;
    localparam logic [6:0] CODE_EOT = 7'h04;

    // Screen geometry
    localparam logic [6:0] COL_LAST = 7'h49;
    localparam logic [6:0] COL_ORIGIN = 7'h00;
    localparam logic [4:0] ROW_LAST = 5'h1A;
    localparam logic [4:0] ROW_FIRST = 5'h00;

    // Serial frame: start, seven data, one zero, three stops
    localparam logic [3:0] BIT_END = 4'hC;
    localparam logic [2:0] FRAME_STOPS = 3'h7;

    // End marker count values
    localparam logic [1:0] EOT_NONE = 2'h0;
    localparam logic [1:0] EOT_ONE = 2'h1;
    localparam logic [1:0] EOT_LIMIT = 2'h2;

    // Register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_BAUD = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [3:0] ADDR_CURS = 4'hC;

    // Control fields
    localparam int CTRL_START = 0;
    localparam int CTRL_RECORD = 1;
    localparam int CTRL_EXTCLK = 2;

    // Status fields
    localparam int STAT_PRINT = 0;
    localparam int STAT_RECV = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_SHIFT = 3;
    localparam int STAT_EOT_LO = 4;
    localparam int STAT_COL_LO = 8;
    localparam int STAT_ROW_LO = 16;

    // Cursor register fields
    localparam int CURS_COL_LO = 0;
    localparam int CURS_ROW_LO = 8;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_READ = 3'b010,
        ST_FETCH = 3'b011,
        ST_LEAD = 3'b100,
        ST_TRAIL = 3'b101,
        ST_SHIFT = 3'b110
    } poseq_state_t;

endpackage

`default_nettype wire

// ---- verilog/poseq_sync.sv ----
`default_nettype none

// Two-stage synchroniser for pins from other domains
module poseq_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_reg; // First stage, read only by second

    // Plain double flop; idle level of every pin is low here
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule // poseq_sync

`default_nettype wire

// ---- tb/poseq_printer.sv ----
`default_nettype none
// Printer stand-in: busy for a shortened print interval
module poseq_printer (
    input wire logic clk_i,
    input wire logic load_i,
    input wire logic cassette_i,
    output logic busy_o,
    output logic ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left_reg = 8'h00; // Cycles of print left
    initial ext_clk_o = 1'b0;
    // Peripheral shift clock runs free, so edges land anywhere
    always #400 ext_clk_o = ~ext_clk_o;
    // Interval longer than a frame, so flow control bites
    always @(posedge clk_i) begin
        if (load_i) left_reg <= 8'hC8;
        else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
    end
    // Cassette output never holds off the flow
    assign busy_o = !cassette_i && (left_reg != 8'h00);
endmodule // poseq_printer
`default_nettype wire

// ---- tb/poseq_top_bench.sv ----
`default_nettype none
module poseq_top_bench import poseq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, arst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic [3:0] avs_address_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
    logic avs_waitrequest_o, printer_busy_i, ext_shift_clk_i, mem_read_restore_o;
    logic load_pulse_o, ser_data_o, print_active_o, receive_mode_o;
    logic cursor_advance_pulse_o, cursor_column_increment_o, cursor_row_increment_o, clear_cursor_column_o, cassette = 0;
    logic [6:0] mem_data_i = 0, cursor_col_o, par_data_o;
    logic [4:0] cursor_row_o;
    int fails = 0, n_tests = 0;
    always #50 clk_i = ~clk_i;
    poseq_top u_poseq_top (.clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .printer_busy_i, .ext_shift_clk_i,
        .mem_data_i, .mem_read_restore_o, .cursor_col_o, .cursor_row_o, .cursor_advance_pulse_o,
        .cursor_column_increment_o, .cursor_row_increment_o, .clear_cursor_column_o,
        .load_pulse_o, .par_data_o, .ser_data_o, .print_active_o, .receive_mode_o);
    poseq_printer u_poseq_printer (.clk_i, .load_i(load_pulse_o), .cassette_i(cassette), .busy_o(printer_busy_i),
        .ext_clk_o(ext_shift_clk_i));
    // Display memory by row and column, blanks elsewhere
    always @(posedge clk_i) begin
        if (mem_read_restore_o) begin
            case ({cursor_row_o, cursor_col_o})
                12'h048: mem_data_i <= 7'h41;
                12'h049: mem_data_i <= 7'h42;
                12'h080: mem_data_i <= 7'h43;
                12'h100: mem_data_i <= 7'h44;
                12'h200: mem_data_i <= 7'h45;
                12'h081, 12'h201: mem_data_i <= CODE_CR; // Stored returns
                12'h101, 12'h102, 12'h280, 12'h300, 12'h301: mem_data_i <= CODE_EOT; // Markers
                default: mem_data_i <= 7'h20;
            endcase
        end
    end
    task automatic print_verdict;
        if (fails == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access; holds everything until waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !w;
        avs_write_i <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        q = avs_readdata_o;
        if (i == 20) begin
            fails++;
            print_verdict();
        end
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // One print pass from a start cell; judges strobes, loads, cursor pulses and the hand-over
    task automatic run(input logic [31:0] ctrl, input logic [31:0] cur, input int n, input logic [69:0] exp,
        input logic [119:0] adr, input logic [31:0] pulses);
        logic [7:0] np [4] = '{8'h00, 8'h00, 8'h00, 8'h00}; // Advance, column, row, clear
        int k = 0, s = 0, gap = 0;
        cassette <= ctrl[CTRL_RECORD];
        bus(1'b1, ADDR_CURS, cur);
        bus(1'b1, ADDR_CTRL, ctrl);
        for (int c = 0; c < 20000 && !(k == n && receive_mode_o); c++) begin
            @(posedge clk_i);
            gap++;
            np[0] += 8'(cursor_advance_pulse_o);
            np[1] += 8'(cursor_column_increment_o);
            np[2] += 8'(cursor_row_increment_o);
            np[3] += 8'(clear_cursor_column_o);
            if (mem_read_restore_o && s < n) begin
                check({cursor_row_o, cursor_col_o}, adr[12*s +: 12]);
                s++;
            end
            if (load_pulse_o && k < n) begin
                check(par_data_o, exp[7*k +: 7]);
                if (k > 0) check(gap > 200, !ctrl[CTRL_RECORD]);
                gap = 0;
                k++;
            end
        end
        check({np[0], np[1], np[2], np[3]}, pulses);
        check({k[3:0], receive_mode_o, print_active_o, ser_data_o}, {n[3:0], 3'b101});
    endtask
    // Peripheral clock: wrap, auto return and newline, stored return, then two markers
    task automatic t_print;
        run(32'h5, 32'h48, 10, {CODE_CR, CODE_CR, 7'h44, CODE_LF, CODE_CR, 7'h43, CODE_LF, CODE_CR, 7'h42, 7'h41},
            {12'h102, 12'h101, 12'h100, 12'h100, 12'h081, 12'h080, 12'h080, 12'h080, 12'h049, 12'h048},
            32'h07050202);
    endtask
    // Cassette recording at internal rate: no insertion, lone marker then blank, two markers
    task automatic t_record;
        bus(1'b1, ADDR_BAUD, 32'h2);
        run(32'h3, 32'h400, 6, {28'h0, CODE_CR, CODE_CR, CODE_LF, CODE_CR, CODE_CR, 7'h45},
            {48'h0, 12'h301, 12'h300, 12'h281, 12'h280, 12'h201, 12'h200}, 32'h06040202);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, ADDR_STAT, 0);
        check(q[1:0], 2'b10);
        t_print();
        t_record();
        print_verdict();
    end
endmodule // poseq_top_bench
`default_nettype wire
